/* common/css_consts.vh */
// Constants for the card supply sequencer: register indices, fields, resets, timing.
// Assumes a 250 MHz ref_clk and an APB slave with byte addresses four times the index.
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH

`define CSS_IDX_EVENTS     16'hfe01
`define CSS_IDX_SUPPLY     16'hfe03
`define CSS_IDX_TIMERS     16'hfe04
`define CSS_IDX_DETECT     16'hfe05
`define CSS_ADDR_W         18

`define CSS_EV_CARD        6
`define CSS_EV_TIMER       5

`define CSS_SUP_SEL_HI     7
`define CSS_SUP_SEL_LO     6
`define CSS_SUP_FAULT      5
`define CSS_SUP_READY_START_ENABLE      4
`define CSS_SUP_GOOD       3
`define CSS_SUP_PWROFF     0

`define CSS_DET_DEBOUNCE   7
`define CSS_DET_ENABLE     6
`define CSS_DET_POL        3
`define CSS_DET_PULLUP_N   2
`define CSS_DET_PULLDN     1
`define CSS_DET_CARDIN     0

`define CSS_TIMERS_RST     8'h0f
`define CSS_DETECT_RST     8'h00
`define CSS_SUPPLY_RST     8'h00

`define CSS_CLK_HZ         250000000
`define CSS_TICK_HZ        32768
`define CSS_TICK_CYC       (`CSS_CLK_HZ / `CSS_TICK_HZ)
`define CSS_DEB_MS         64
`define CSS_DEB_TICKS      ((`CSS_DEB_MS * `CSS_TICK_HZ) / 1000)

`endif

/* verilog/css_card_supply_sequencer.v */
// Card supply sequencer: APB registers, 32768 Hz timebase, supply state machine, card detect.
// Assumes pins supply_good, core_fault, vbus_present and card_detect_pin are asynchronous;
// contacts_idle comes from the contact sequencer on ref_clk.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "css_consts.vh"

// Functional notes
// - Non-zero selection starts activation; 01 is 1.8V.
// - Card event or supply loss deactivates; supply off last.
// - Core fault clears fault bit and selection.
// - Ready-start set: activate once supply good.
// - Ready-start clear: activate at timer expiry if supply good.
// - Supply-good bit is read only.
// - Bit 0 requests whole chip power off.
// - Power off waits until bus power removed.
// - Stable timer starts when activation begins.
// - Stable interval is count times 32768 Hz period.
// - Supply bad at expiry: event flag, deactivate, clear.
// - Zero stable count disables timeout entirely.
// - Firmware clear delays deactivation by off count.
// - No off delay for emergencies; zero adds none.
// - Card detect works without smart card clock.
// - Power-down bit: presence reported, no debounce.
// - Timer expiry sets flag; reading clears it.
module css_card_supply_sequencer #(
    parameter TICK_DIV = `CSS_TICK_CYC
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [17:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        supply_good,
    input  wire        core_fault,
    input  wire        vbus_present,
    input  wire        card_detect_pin,
    input  wire        power_down_bit,
    input  wire        contacts_idle,
    output reg         card_supply_en_q,
    output reg  [1:0]  card_voltage_q,
    output reg         contact_active_q,
    output reg         core_supply_off_q,
    output reg         detect_pullup_n_q,
    output reg         detect_pulldown_q
);

    localparam [4:0] ST_OFF  = 5'h01;
    localparam [4:0] ST_WAIT = 5'h02;
    localparam [4:0] ST_ON   = 5'h04;
    localparam [4:0] ST_DLY  = 5'h08;
    localparam [4:0] ST_DEA  = 5'h10;
    localparam [7:0] SUP_RST = `CSS_SUPPLY_RST;

    function hit;
        input [17:0] addr;
        input [15:0] idx;
        begin
            hit = (addr == {idx, 2'b00});
        end
    endfunction

    reg  [4:0]  state_q;
    reg  [1:0]  sel_q;
    reg         fault_bit_q;
    reg         ready_start_enable_q;
    reg         pwroff_q;
    reg  [7:0]  timers_q;
    reg  [7:0]  detect_q;
    reg         ev_card_q;
    reg         ev_timer_q;
    reg         need_zero_q;
    reg  [12:0] div_q;
    reg         tick_q;
    reg  [3:0]  tmr_q;
    reg  [11:0] deb_q;
    reg         cardin_q;
    reg  [3:0]  s1_q;
    reg  [3:0]  s2_q;
    reg         fault_d1_q;
    reg  [7:0]  rdata_d;

    wire good     = s2_q[0];
    wire fault_in = s2_q[1];
    wire vbus     = s2_q[2];
    wire det_raw  = s2_q[3];

    wire apb_do   = psel & penable & pready;
    wire wr       = apb_do & pwrite;
    wire rd       = apb_do & ~pwrite;
    wire wr_sup   = wr & hit(paddr, `CSS_IDX_SUPPLY);
    wire wr_tmr   = wr & hit(paddr, `CSS_IDX_TIMERS);
    wire wr_det   = wr & hit(paddr, `CSS_IDX_DETECT);
    wire rd_ev    = rd & hit(paddr, `CSS_IDX_EVENTS);
    wire mapped   = hit(paddr, `CSS_IDX_EVENTS) | hit(paddr, `CSS_IDX_SUPPLY) |
                    hit(paddr, `CSS_IDX_TIMERS) | hit(paddr, `CSS_IDX_DETECT);

    wire fault_ev = fault_in & ~fault_d1_q;
    wire present  = (det_raw == detect_q[`CSS_DET_POL]);
    wire det_on   = detect_q[`CSS_DET_ENABLE];
    wire deb_on   = detect_q[`CSS_DET_DEBOUNCE] & ~power_down_bit;
    wire cardin_d = det_on & present &
                    (~deb_on | cardin_q | (deb_q == `CSS_DEB_TICKS));
    wire card_ev  = cardin_d ^ cardin_q;
    wire emerg    = card_ev | ~good;
    wire expiry   = tick_q & (tmr_q == 4'h1);
    wire act_busy = state_q[1] | state_q[2] | state_q[3];
    wire fail_exp = state_q[1] & (timers_q[3:0] != 4'h0) & expiry & ~good;

    // Pins pass two flip-flops before use.
    always @(posedge ref_clk) begin
        if (rst) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            fault_d1_q <= 1'b0;
        end else begin
            s1_q <= {card_detect_pin, vbus_present, core_fault, supply_good};
            s2_q <= s1_q;
            fault_d1_q <= fault_in;
        end
    end

    // Divider makes the 32768 Hz tick enable.
    always @(posedge ref_clk) begin
        if (rst) begin
            div_q <= 13'h0000;
            tick_q <= 1'b0;
        end else if (div_q == TICK_DIV[12:0] - 13'h0001) begin
            div_q <= 13'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 13'h0001;
            tick_q <= 1'b0;
        end
    end

    // Card presence with optional debounce, release is immediate.
    always @(posedge ref_clk) begin
        if (rst) begin
            deb_q <= 12'h000;
            cardin_q <= 1'b0;
        end else begin
            cardin_q <= cardin_d;
            if (~det_on | ~present | ~deb_on) begin
                deb_q <= 12'h000;
            end else if (tick_q & (deb_q != `CSS_DEB_TICKS)) begin
                deb_q <= deb_q + 12'h001;
            end
        end
    end

    // Supply state machine with its tick counter.
    always @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_OFF;
            tmr_q <= 4'h0;
            card_supply_en_q <= 1'b0;
            card_voltage_q <= 2'b00;
            contact_active_q <= 1'b0;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (sel_q != 2'b00 && !need_zero_q) begin
                        state_q <= ST_WAIT;
                        tmr_q <= timers_q[3:0];
                        card_supply_en_q <= 1'b1;
                        card_voltage_q <= sel_q;
                    end
                end
                ST_WAIT: begin
                    if (sel_q == 2'b00 || card_ev) begin
                        state_q <= ST_DEA;
                    end else if (ready_start_enable_q && good) begin
                        state_q <= ST_ON;
                        contact_active_q <= 1'b1;
                    end else if (timers_q[3:0] != 4'h0 && expiry) begin
                        if (good) begin
                            state_q <= ST_ON;
                            contact_active_q <= 1'b1;
                        end else begin
                            state_q <= ST_DEA;
                        end
                    end else if (tick_q && timers_q[3:0] != 4'h0) begin
                        tmr_q <= tmr_q - 4'h1;
                    end
                end
                ST_ON: begin
                    if (emerg || fault_ev) begin
                        state_q <= ST_DEA;
                        contact_active_q <= 1'b0;
                    end else if (sel_q == 2'b00) begin
                        tmr_q <= timers_q[7:4];
                        if (timers_q[7:4] == 4'h0) begin
                            state_q <= ST_DEA;
                            contact_active_q <= 1'b0;
                        end else begin
                            state_q <= ST_DLY;
                        end
                    end
                end
                ST_DLY: begin
                    if (emerg || fault_ev || expiry) begin
                        state_q <= ST_DEA;
                        contact_active_q <= 1'b0;
                    end else if (tick_q) begin
                        tmr_q <= tmr_q - 4'h1;
                    end
                end
                ST_DEA: begin
                    contact_active_q <= 1'b0;
                    if (contacts_idle && !contact_active_q) begin
                        state_q <= ST_OFF;
                        card_supply_en_q <= 1'b0;
                        card_voltage_q <= 2'b00;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Software registers; hardware clears of the selection win over writes.
    always @(posedge ref_clk) begin
        if (rst) begin
            sel_q <= SUP_RST[`CSS_SUP_SEL_HI:`CSS_SUP_SEL_LO];
            fault_bit_q <= 1'b0;
            ready_start_enable_q <= 1'b0;
            pwroff_q <= 1'b0;
            timers_q <= `CSS_TIMERS_RST;
            detect_q <= `CSS_DETECT_RST;
            need_zero_q <= 1'b0;
        end else begin
            if (wr_sup) begin
                sel_q <= pwdata[`CSS_SUP_SEL_HI:`CSS_SUP_SEL_LO];
                fault_bit_q <= pwdata[`CSS_SUP_FAULT];
                ready_start_enable_q <= pwdata[`CSS_SUP_READY_START_ENABLE];
                pwroff_q <= pwdata[`CSS_SUP_PWROFF];
                if (pwdata[`CSS_SUP_SEL_HI:`CSS_SUP_SEL_LO] == 2'b00) begin
                    need_zero_q <= 1'b0;
                end
            end
            if (wr_tmr) begin
                timers_q <= pwdata[7:0];
            end
            if (wr_det) begin
                detect_q <= pwdata[7:0];
            end
            // Only a card event, a loss of an established supply or a failed expiry locks out.
            if ((act_busy && card_ev) || ((state_q[2] | state_q[3]) && ~good) || fail_exp) begin
                need_zero_q <= 1'b1;
            end
            if (fault_ev) begin
                fault_bit_q <= 1'b0;
                sel_q <= 2'b00;
            end else if (fail_exp) begin
                sel_q <= 2'b00;
            end
        end
    end

    // Sticky event flags, cleared by reading; a new event wins.
    always @(posedge ref_clk) begin
        if (rst) begin
            ev_card_q <= 1'b0;
            ev_timer_q <= 1'b0;
        end else begin
            ev_card_q <= (card_ev | fail_exp) | (ev_card_q & ~rd_ev);
            ev_timer_q <= (state_q[1] & (timers_q[3:0] != 4'h0) & expiry) |
                          (ev_timer_q & ~rd_ev);
        end
    end

    // Chip power off takes effect only without bus power.
    always @(posedge ref_clk) begin
        if (rst) begin
            core_supply_off_q <= 1'b0;
            detect_pullup_n_q <= 1'b0;
            detect_pulldown_q <= 1'b0;
        end else begin
            core_supply_off_q <= pwroff_q & ~vbus;
            detect_pullup_n_q <= detect_q[`CSS_DET_PULLUP_N];
            detect_pulldown_q <= detect_q[`CSS_DET_PULLDN];
        end
    end

    // Read data mux.
    always @* begin
        rdata_d = 8'h00;
        if (hit(paddr, `CSS_IDX_EVENTS)) begin
            rdata_d[`CSS_EV_CARD] = ev_card_q;
            rdata_d[`CSS_EV_TIMER] = ev_timer_q;
        end else if (hit(paddr, `CSS_IDX_SUPPLY)) begin
            rdata_d = {sel_q, fault_bit_q, ready_start_enable_q, good, 2'b00, pwroff_q};
        end else if (hit(paddr, `CSS_IDX_TIMERS)) begin
            rdata_d = timers_q;
        end else if (hit(paddr, `CSS_IDX_DETECT)) begin
            rdata_d = {detect_q[7:6], 2'b00, detect_q[3:1], cardin_q};
        end
    end

    // APB slave with one wait state.
    always @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= {24'h000000, rdata_d};
            end
        end
    end

endmodule

/* verif/css_card_model.sv */
// Card side of the slot: supply ramp to supply_good and contact idle report.
// Assumes the sequencer outputs on ref_clk; alive low models a card whose supply never settles.
`timescale 1ns/10ps
module css_card_model (
    input  wire logic ref_clk,
    input  wire logic card_supply_en_q,
    input  wire logic contact_active_q,
    input  wire logic alive,
    output logic      supply_good,
    output logic      contacts_idle
);
    int ramp = 0;
    initial supply_good = 1'b0;
    initial contacts_idle = 1'b1;
    always @(posedge ref_clk) begin
        ramp <= card_supply_en_q ? ramp + 1 : 0;
        supply_good <= alive && card_supply_en_q && ramp > 5;
        contacts_idle <= !contact_active_q;
    end
endmodule

/* verif/css_sequencer_props.sv */
// Checker for the card supply sequencer ports.
// Assumes it is bound into css_card_supply_sequencer.
`timescale 1ns/10ps
module css_sequencer_props (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       supply_good,
    input wire logic       core_fault,
    input wire logic       vbus_present,
    input wire logic       contacts_idle,
    input wire logic       card_supply_en_q,
    input wire logic [1:0] card_voltage_q,
    input wire logic       contact_active_q,
    input wire logic       core_supply_off_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    ready_wait_a: assert property ($rose(penable) && psel |-> ##[1:2] pready)
        else $error("pready late");
    sel_nonzero_a: assert property ($rose(card_supply_en_q) |-> card_voltage_q != 2'b00)
        else $error("supply on with zero code");
    volt_off_a: assert property (!card_supply_en_q |-> card_voltage_q == 2'b00)
        else $error("voltage code while off");
    contact_supply_a: assert property (contact_active_q |-> card_supply_en_q)
        else $error("contacts active without supply");
    supply_last_a: assert property ($fell(card_supply_en_q) |->
        !$past(contact_active_q) && $past(contacts_idle))
        else $error("supply off before contacts idle");
    active_good_a: assert property ($rose(contact_active_q) |-> $past(supply_good, 2))
        else $error("activation without supply good");
    fault_deact_a: assert property ($rose(core_fault) |-> ##[1:8] !contact_active_q)
        else $error("core fault did not deactivate");
    core_off_a: assert property ($rose(core_supply_off_q) |-> !$past(vbus_present, 2))
        else $error("core off with bus power");
    cover property ($rose(contact_active_q));
    cover property ($fell(card_supply_en_q));
    cover property ($rose(core_supply_off_q));
    cover property (pslverr);
endmodule
bind css_card_supply_sequencer css_sequencer_props u_props (.ref_clk, .rst, .psel, .penable,
    .pready, .pslverr, .supply_good, .core_fault, .vbus_present, .contacts_idle,
    .card_supply_en_q, .card_voltage_q, .contact_active_q, .core_supply_off_q);

/* verif/card_supply_sequencer_test.sv */
// Self-checking bench for the card supply sequencer over APB.
// Assumes the card model and a tick divider of 4 cycles.
`timescale 1ns/10ps
module card_supply_sequencer_test;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic        core_fault = 0, vbus_present = 0, card_detect_pin = 0;
    logic        power_down_bit = 0, alive = 1;
    logic [7:0]  tv, dv;
    wire  [31:0] prdata;
    wire         pready, pslverr, supply_good, contacts_idle, card_supply_en_q;
    wire         contact_active_q, core_supply_off_q, detect_pullup_n_q, detect_pulldown_q;
    wire  [1:0]  card_voltage_q;
    int          errors = 0, compares = 0, cyc = 0, n, c;
    int          mirror[int];
    localparam   CA = 0, EN = 1, CO = 2;
    always #2 ref_clk = ~ref_clk;
    css_card_supply_sequencer #(.TICK_DIV(4)) DUT (.ref_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_good, .core_fault, .vbus_present,
        .card_detect_pin, .power_down_bit, .contacts_idle, .card_supply_en_q, .card_voltage_q,
        .contact_active_q, .core_supply_off_q, .detect_pullup_n_q, .detect_pulldown_q);
    css_card_model card (.ref_clk, .card_supply_en_q, .contact_active_q, .alive, .supply_good,
        .contacts_idle);
    task automatic chk(input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input bit w, input [15:0] i, input [7:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (w) mirror[i] = d;
    endtask
    task automatic rdc(input [15:0] i, input [7:0] e);
        apb(0, i, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    function automatic logic sig(input int s);
        case (s)
            CA: return contact_active_q;
            EN: return card_supply_en_q;
            default: return core_supply_off_q;
        endcase
    endfunction
    task automatic wt(input int s, input bit v, input int lim);
        for (n = 0; n < lim && sig(s) !== v; n++) @(negedge ref_clk);
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop;
        end
    end
    initial begin
        void'($urandom(45));
        repeat (20) @(posedge ref_clk);
        rst <= 0;
        rdc(16'hfe04, 8'h0f);
        rdc(16'hfe05, 8'h00);
        rdc(16'hfe03, 8'h00);
        apb(0, 16'hfe07, 8'h00);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        tv = $urandom;
        apb(1, 16'hfe04, tv);
        rdc(16'hfe04, mirror[16'hfe04]);
        dv = $urandom & 8'h0e;
        apb(1, 16'hfe05, dv);
        apb(0, 16'hfe05, 8'h00);
        chk(rd, mirror[16'hfe05]);
        chk({detect_pullup_n_q, detect_pulldown_q}, dv[2:1]);
        apb(1, 16'hfe04, 8'h00);
        apb(1, 16'hfe03, 8'h08);
        rdc(16'hfe03, 8'h00);
        for (c = 1; c < 4; c++) begin
            apb(1, 16'hfe03, {c[1:0], 6'h10});
            wt(CA, 1, 60);
            chk({contact_active_q, card_voltage_q}, 4 + c);
            rdc(16'hfe03, {c[1:0], 6'h18});
            apb(1, 16'hfe03, 8'h00);
            wt(EN, 0, 30);
            chk(card_supply_en_q, 0);
        end
        alive <= 0;
        apb(1, 16'hfe04, 8'h03);
        apb(1, 16'hfe03, 8'h40);
        wt(EN, 1, 20);
        wt(EN, 0, 100);
        chk(n >= 8 && n <= 20, 1);
        rdc(16'hfe01, 8'h60);
        rdc(16'hfe01, 8'h00);
        rdc(16'hfe03, 8'h00);
        apb(1, 16'hfe03, 8'h40);
        repeat (8) @(negedge ref_clk);
        chk(card_supply_en_q, 0);
        apb(1, 16'hfe03, 8'h00);
        alive <= 1;
        apb(1, 16'hfe04, 8'h50);
        apb(1, 16'hfe03, 8'h50);
        wt(CA, 1, 60);
        chk(contact_active_q, 1);
        apb(1, 16'hfe03, 8'h00);
        wt(CA, 0, 60);
        chk(n >= 15 && n <= 26, 1);
        wt(EN, 0, 30);
        apb(1, 16'hfe03, 8'h70);
        wt(CA, 1, 60);
        @(posedge ref_clk);
        core_fault <= 1;
        wt(CA, 0, 8);
        chk(contact_active_q, 0);
        wt(EN, 0, 30);
        repeat (4) @(negedge ref_clk);
        rdc(16'hfe03, 8'h10);
        core_fault <= 0;
        power_down_bit <= 1;
        apb(0, 16'hfe01, 8'h00);
        apb(1, 16'hfe05, 8'h08);
        apb(1, 16'hfe05, 8'h48);
        apb(1, 16'hfe03, 8'h50);
        wt(CA, 1, 60);
        @(posedge ref_clk);
        card_detect_pin <= 1;
        wt(EN, 0, 40);
        chk(card_supply_en_q, 0);
        rdc(16'hfe05, 8'h49);
        rdc(16'hfe01, 8'h40);
        apb(1, 16'hfe03, 8'h00);
        vbus_present <= 1;
        apb(1, 16'hfe03, 8'h01);
        wt(CO, 1, 10);
        chk(core_supply_off_q, 0);
        @(posedge ref_clk);
        vbus_present <= 0;
        wt(CO, 1, 10);
        chk(core_supply_off_q, 1);
        report_and_stop;
    end
endmodule
